// *** design/cec_pkg.sv ***
// Package: constants, register map and state records for the counter unit
`default_nettype none
package cec_pkg;
  // Clock rates, the main clock stands in for fc
  localparam int unsigned FC_HZ      = 10_000_000;
  localparam int unsigned FS_HZ      = 32_768;
  localparam int unsigned FS_DIV     = FC_HZ / FS_HZ;
  localparam int unsigned FS_DIV_W   = 9;
  localparam int unsigned PRE_W      = 11;
  // Prescaler tap exponents
  localparam int unsigned SH_FC2     = 1;
  localparam int unsigned SH_FC8     = 3;
  localparam int unsigned SH_FC32    = 5;
  localparam int unsigned SH_FC128   = 7;
  localparam int unsigned SH_FC2K    = 11;
  localparam int unsigned SH_FS8     = 3;
  // Enable vector indices
  localparam int unsigned EN_FC2     = 0;
  localparam int unsigned EN_FC8     = 1;
  localparam int unsigned EN_FC32    = 2;
  localparam int unsigned EN_FC128   = 3;
  localparam int unsigned EN_FC2K    = 4;
  localparam int unsigned EN_FS      = 5;
  localparam int unsigned EN_FS8     = 6;
  localparam int unsigned EN_N       = 7;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PER_LO  = 8'h04;
  localparam logic [7:0] OFS_PER_HI  = 8'h08;
  localparam logic [7:0] OFS_DUTY_LO = 8'h0c;
  localparam logic [7:0] OFS_DUTY_HI = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  // Control and status field positions
  localparam int unsigned CTL_RUN    = 0;
  localparam int unsigned CTL_PWM    = 1;
  localparam int unsigned CTL_CLK_LO = 2;
  localparam int unsigned CTL_TAP    = 5;
  localparam int unsigned CTL_SLOW   = 6;
  localparam int unsigned CTL_INIT   = 7;
  localparam int unsigned STA_FF     = 16;
  // Source clock select codes
  localparam logic [2:0] SRC_SLOWTAP = 3'h0;
  localparam logic [2:0] SRC_FC128   = 3'h1;
  localparam logic [2:0] SRC_FC32    = 3'h2;
  localparam logic [2:0] SRC_FC8     = 3'h3;
  localparam logic [2:0] SRC_FS      = 3'h4;
  localparam logic [2:0] SRC_FC2     = 3'h5;
  localparam logic [2:0] SRC_FC      = 3'h6;
  localparam logic [2:0] SRC_PIN     = 3'h7;
  // Reset values and counter maximum
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;

  typedef struct packed {
    logic [PRE_W-1:0]    div;
    logic [FS_DIV_W-1:0] fs_cnt;
    logic [SH_FS8-1:0]   fs8_cnt;
    logic [EN_N-1:0]     en;
  } cec_pre_s;

  typedef struct packed {
    logic        run;
    logic        pwm_mode;
    logic [2:0]  clk_sel;
    logic        tap_sel;
    logic        low_speed;
    logic        ff_init;
  } cec_ctrl_s;

  typedef struct packed {
    cec_ctrl_s   ctrl;
    logic [7:0]  per_lo;
    logic [7:0]  per_hi;
    logic [15:0] duty_buf;
    logic [15:0] duty_act;
    logic [15:0] cnt;
    logic        ff;
    logic        out;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
    logic [2:0]  sync;
    logic        pin_lvl;
  } cec_state_s;
endpackage
`default_nettype wire

// *** design/cec_prescaler.sv ***
// Prescaler: one-cycle enables for every source clock tap
`default_nettype none
module cec_prescaler #(
  parameter int unsigned FS_DIV = cec_pkg::FS_DIV
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  output logic [cec_pkg::EN_N-1:0]       en_o
);
  cec_pkg::cec_pre_s s_q;
  cec_pkg::cec_pre_s s_d;
  logic              fs_hit;

  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + 1'b1;
    // Tap fires when its low bits are all ones
    s_d.en[cec_pkg::EN_FC2] = &s_q.div[cec_pkg::SH_FC2-1:0];
    s_d.en[cec_pkg::EN_FC8] = &s_q.div[cec_pkg::SH_FC8-1:0];
    s_d.en[cec_pkg::EN_FC32] = &s_q.div[cec_pkg::SH_FC32-1:0];
    s_d.en[cec_pkg::EN_FC128] = &s_q.div[cec_pkg::SH_FC128-1:0];
    s_d.en[cec_pkg::EN_FC2K] = &s_q.div[cec_pkg::SH_FC2K-1:0];
    // Subclock fs is emulated from the main clock
    fs_hit = (s_q.fs_cnt == cec_pkg::FS_DIV_W'(FS_DIV - 1));
    s_d.fs_cnt = fs_hit ? '0 : s_q.fs_cnt + 1'b1;
    s_d.en[cec_pkg::EN_FS] = fs_hit;
    s_d.fs8_cnt = fs_hit ? s_q.fs8_cnt + 1'b1 : s_q.fs8_cnt;
    s_d.en[cec_pkg::EN_FS8] = fs_hit & (&s_q.fs8_cnt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign en_o = s_q.en;
endmodule
`default_nettype wire

// *** design/cec_counter16.sv ***
// Cascaded 16-bit event counter and PWM generator with Wishbone registers
// Summary of operation
// - Both bytes form one 16-bit counter
// - Event mode counts input falling edges
// - Counting starts only when run bit set
// - Event match raises request, clears counter
// - After clear, counting resumes on next edge
// - Period compare is unbuffered, used at once
// - PWM counts prescaler tap or input pin
// - Duty match toggles flop, counting continues
// - Overflow toggles flop, clears, raises request
// - Flop loads initial bit, resets to zero
// - Output pin is inverse of flop
// - Duty double-buffered: request or stopped transfer
// - Duty read returns the active stage
// - Stop holds output; initial bit after stop
// - fc taps gated by speed mode; fs and pin not
`default_nettype none
module cec_counter16 #(
  parameter int unsigned FS_DIV = cec_pkg::FS_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        event_input_pin_i,
  output logic             pwm_out_pin_o,
  output logic             upper_timer_irq_o
);
  cec_pkg::cec_state_s      s_q;
  cec_pkg::cec_state_s      s_d;
  logic [cec_pkg::EN_N-1:0] en;
  logic                     req;
  logic                     wr;
  logic                     wr_b0;
  logic                     fall;
  logic                     src_tick;
  logic                     tick;
  logic [8:0]               lo_sum;
  logic [15:0]              cnt_inc;
  logic [15:0]              period;

  cec_prescaler #(
    .FS_DIV (FS_DIV)
  ) u_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_o  (en)
  );

  assign req    = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr     = req & wb_we_i;
  assign wr_b0  = wr & wb_sel_i[0];
  assign period = {s_q.per_hi, s_q.per_lo};
  // Three stages: a metastable first stage is never trusted
  // Input level accepted only once stages two and three agree
  assign fall = (s_q.sync[1] == s_q.sync[2]) & ~s_q.sync[2] & s_q.pin_lvl;

  always_comb begin
    src_tick = 1'b0;
    unique case (s_q.ctrl.clk_sel)
      cec_pkg::SRC_SLOWTAP: begin
        src_tick = (s_q.ctrl.tap_sel | s_q.ctrl.low_speed)
                   ? en[cec_pkg::EN_FS8] : en[cec_pkg::EN_FC2K];
      end
      cec_pkg::SRC_FS:   src_tick = en[cec_pkg::EN_FS];
      cec_pkg::SRC_PIN:  src_tick = fall;
      cec_pkg::SRC_FC128: begin
        src_tick = ~s_q.ctrl.low_speed & en[cec_pkg::EN_FC128];
      end
      cec_pkg::SRC_FC32: begin
        src_tick = ~s_q.ctrl.low_speed & en[cec_pkg::EN_FC32];
      end
      cec_pkg::SRC_FC8: begin
        src_tick = ~s_q.ctrl.low_speed & en[cec_pkg::EN_FC8];
      end
      cec_pkg::SRC_FC2: begin
        src_tick = ~s_q.ctrl.low_speed & en[cec_pkg::EN_FC2];
      end
      cec_pkg::SRC_FC:   src_tick = ~s_q.ctrl.low_speed;
    endcase
  end

  assign tick = s_q.ctrl.run & (s_q.ctrl.pwm_mode ? src_tick : fall);

  assign lo_sum  = {1'b0, s_q.cnt[7:0]} + 9'h001;
  assign cnt_inc = {s_q.cnt[15:8] + {7'h00, lo_sum[8]}, lo_sum[7:0]};

  always_comb begin
    s_d       = s_q;
    s_d.irq   = 1'b0;
    s_d.ack   = req;
    s_d.sync  = {s_q.sync[1:0], event_input_pin_i};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.pin_lvl = s_q.sync[2];
    end
    // Register writes land on the acknowledging edge
    if (wr_b0) begin
      unique case (wb_adr_i)
        cec_pkg::OFS_CTRL: begin
          // Fields by bit position, not by record order
          s_d.ctrl.run       = wb_dat_i[cec_pkg::CTL_RUN];
          s_d.ctrl.pwm_mode  = wb_dat_i[cec_pkg::CTL_PWM];
          s_d.ctrl.clk_sel   = wb_dat_i[cec_pkg::CTL_CLK_LO +: 3];
          s_d.ctrl.tap_sel   = wb_dat_i[cec_pkg::CTL_TAP];
          s_d.ctrl.low_speed = wb_dat_i[cec_pkg::CTL_SLOW];
          s_d.ctrl.ff_init   = wb_dat_i[cec_pkg::CTL_INIT];
          if (!s_q.ctrl.run) begin
            s_d.ff = wb_dat_i[cec_pkg::CTL_INIT];
          end
        end
        cec_pkg::OFS_PER_LO:  s_d.per_lo = wb_dat_i[7:0];
        cec_pkg::OFS_PER_HI:  s_d.per_hi = wb_dat_i[7:0];
        cec_pkg::OFS_DUTY_LO: s_d.duty_buf[7:0] = wb_dat_i[7:0];
        cec_pkg::OFS_DUTY_HI: s_d.duty_buf[15:8] = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        cec_pkg::OFS_CTRL: begin
          s_d.rdata = 32'h00000000;
          s_d.rdata[cec_pkg::CTL_RUN] = s_q.ctrl.run;
          s_d.rdata[cec_pkg::CTL_PWM] = s_q.ctrl.pwm_mode;
          s_d.rdata[cec_pkg::CTL_CLK_LO +: 3] = s_q.ctrl.clk_sel;
          s_d.rdata[cec_pkg::CTL_TAP] = s_q.ctrl.tap_sel;
          s_d.rdata[cec_pkg::CTL_SLOW] = s_q.ctrl.low_speed;
          s_d.rdata[cec_pkg::CTL_INIT] = s_q.ctrl.ff_init;
        end
        cec_pkg::OFS_PER_LO:  s_d.rdata = {24'h000000, s_q.per_lo};
        cec_pkg::OFS_PER_HI:  s_d.rdata = {24'h000000, s_q.per_hi};
        cec_pkg::OFS_DUTY_LO: s_d.rdata = {24'h000000, s_q.duty_act[7:0]};
        cec_pkg::OFS_DUTY_HI: s_d.rdata = {24'h000000, s_q.duty_act[15:8]};
        cec_pkg::OFS_STATUS:  s_d.rdata = {15'h0000, s_q.ff, s_q.cnt};
        default:              s_d.rdata = 32'h00000000;
      endcase
    end
    if (!s_q.ctrl.run) begin
      s_d.cnt = 16'h0000;
      s_d.duty_act = s_q.duty_buf;
    end else if (tick) begin
      if (s_q.ctrl.pwm_mode) begin
        if (s_q.cnt == cec_pkg::CNT_MAX) begin
          s_d.cnt      = 16'h0000;
          s_d.ff       = ~s_q.ff;
          s_d.irq      = 1'b1;
          // A duty write in this cycle moves the old bytes
          // running: transfer at the request
          s_d.duty_act = s_q.duty_buf;
        end else begin
          s_d.cnt = cnt_inc;
          if (cnt_inc == s_q.duty_act) begin
            s_d.ff = ~s_q.ff;
          end
        end
      end else begin
        if (cnt_inc == period) begin
          s_d.cnt = 16'h0000;
          s_d.irq = 1'b1;
        end else begin
          s_d.cnt = cnt_inc;
        end
      end
    end
    s_d.out = ~s_d.ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q          <= '0;
      s_q.ctrl     <= cec_pkg::CTRL_RST;
      s_q.duty_buf <= cec_pkg::CMP_RST;
      s_q.duty_act <= cec_pkg::CMP_RST;
      s_q.out      <= 1'b1;
      s_q.sync     <= 3'h7;
      s_q.pin_lvl  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o          = s_q.rdata;
  assign wb_ack_o          = s_q.ack;
  assign pwm_out_pin_o     = s_q.out;
  assign upper_timer_irq_o = s_q.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_duty_hi_wr_stopped;
    wr_b0 && wb_adr_i == cec_pkg::OFS_DUTY_HI && !s_q.ctrl.run;
  endsequence
  sequence s_quiet_stop;
    !wr && !s_q.ctrl.run;
  endsequence

  property p_stopped_idle;
    !s_q.ctrl.run |=> s_q.cnt == 16'h0000 && !upper_timer_irq_o;
  endproperty
  a_stopped_idle: assert property (p_stopped_idle)
    else $error("counter moved while stopped");

  property p_pin_inverse;
    pwm_out_pin_o == ~s_q.ff;
  endproperty
  a_pin_inverse: assert property (p_pin_inverse)
    else $error("output pin not inverse of flop");

  property p_event_match;
    s_q.ctrl.run && !s_q.ctrl.pwm_mode && fall && cnt_inc == period
      |=> upper_timer_irq_o && s_q.cnt == 16'h0000;
  endproperty
  a_event_match: assert property (p_event_match)
    else $error("event match did not request and clear");

  property p_event_edge;
    s_q.ctrl.run && !s_q.ctrl.pwm_mode && fall && cnt_inc != period
      |=> s_q.cnt == $past(s_q.cnt) + 16'h0001 && !upper_timer_irq_o;
  endproperty
  a_event_edge: assert property (p_event_edge)
    else $error("falling edge not counted");

  property p_pwm_overflow;
    s_q.ctrl.run && s_q.ctrl.pwm_mode && src_tick
      && s_q.cnt == cec_pkg::CNT_MAX
      |=> upper_timer_irq_o && s_q.cnt == 16'h0000
          && s_q.ff != $past(s_q.ff);
  endproperty
  a_pwm_overflow: assert property (p_pwm_overflow)
    else $error("overflow handling wrong");

  property p_pwm_match;
    s_q.ctrl.run && s_q.ctrl.pwm_mode && src_tick
      && s_q.cnt != cec_pkg::CNT_MAX && cnt_inc == s_q.duty_act
      |=> s_q.ff != $past(s_q.ff) && s_q.cnt != 16'h0000
          ##1 pwm_out_pin_o == ~s_q.ff;
  endproperty
  a_pwm_match: assert property (p_pwm_match)
    else $error("duty match did not toggle");

  property p_duty_stopped;
    s_duty_hi_wr_stopped ##1 s_quiet_stop
      |=> s_q.duty_act == s_q.duty_buf;
  endproperty
  a_duty_stopped: assert property (p_duty_stopped)
    else $error("stopped duty transfer missing");

  property p_duty_hold;
    s_q.ctrl.run && !(s_q.ctrl.pwm_mode && tick
      && s_q.cnt == cec_pkg::CNT_MAX)
      |=> s_q.duty_act == $past(s_q.duty_act);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("active duty changed between requests");

  property p_slow_gate;
    s_q.ctrl.low_speed && s_q.ctrl.clk_sel != cec_pkg::SRC_SLOWTAP
      && s_q.ctrl.clk_sel != cec_pkg::SRC_FS
      && s_q.ctrl.clk_sel != cec_pkg::SRC_PIN |-> !src_tick;
  endproperty
  a_slow_gate: assert property (p_slow_gate)
    else $error("fast tap active in low-speed mode");

  property p_stop_holds;
    $fell(s_q.ctrl.run) |-> ##1 s_q.ff == $past(s_q.ff)
      && pwm_out_pin_o == $past(pwm_out_pin_o);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("stop changed the output level");

  property p_irq_pulse;
    upper_timer_irq_o |=> !upper_timer_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("request stood longer than one cycle");

  property p_irq_clears;
    upper_timer_irq_o |-> s_q.cnt == 16'h0000;
  endproperty
  a_irq_clears: assert property (p_irq_clears)
    else $error("counter not cleared with request");

  property p_carry;
    s_q.ctrl.pwm_mode && tick && s_q.cnt[7:0] == 8'hff
      && s_q.cnt != cec_pkg::CNT_MAX
      |=> s_q.cnt == {$past(s_q.cnt[15:8]) + 8'h01, 8'h00};
  endproperty
  a_carry: assert property (p_carry)
    else $error("low byte carry lost");

  property p_init_load;
    wr_b0 && wb_adr_i == cec_pkg::OFS_CTRL && !s_q.ctrl.run
      |=> s_q.ff == $past(wb_dat_i[cec_pkg::CTL_INIT]);
  endproperty
  a_init_load: assert property (p_init_load)
    else $error("flop not loaded from initial bit");

  property p_period_now;
    wr_b0 && wb_adr_i == cec_pkg::OFS_PER_LO
      |=> s_q.per_lo == $past(wb_dat_i[7:0]);
  endproperty
  a_period_now: assert property (p_period_now)
    else $error("period byte not taken at once");

  property p_src_fc;
    s_q.ctrl.run && s_q.ctrl.pwm_mode && !s_q.ctrl.low_speed
      && s_q.ctrl.clk_sel == cec_pkg::SRC_FC |-> tick;
  endproperty
  a_src_fc: assert property (p_src_fc)
    else $error("main clock source did not tick");

  property p_event_quiet;
    s_q.ctrl.run && !s_q.ctrl.pwm_mode && !fall
      |=> s_q.cnt == $past(s_q.cnt);
  endproperty
  a_event_quiet: assert property (p_event_quiet)
    else $error("counter moved without an edge");
endmodule
`default_nettype wire

// *** bench/cec_pulse_src.sv ***
// Partner model: external event pulse source and PWM output load
`default_nettype none
module cec_pulse_src (
  input  wire logic clk_i,
  input  wire logic pwm_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cyc      = 0;
  int unsigned rise_cyc = 0;
  int unsigned fall_cyc = 0;
  logic        pwm_q    = 1'b1;
  initial pin_o = 1'b1;
  task automatic pulse(input int n);
    repeat (n) begin
      pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // port latch taken as set: load sees the pin
  always @(posedge clk_i) begin
    cyc   <= cyc + 1;
    pwm_q <= pwm_i;
    if (pwm_q === 1'b0 && pwm_i === 1'b1) rise_cyc <= cyc;
    if (pwm_q === 1'b1 && pwm_i === 1'b0) fall_cyc <= cyc;
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Testbench: register-level tests of the cascaded counter
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ev_pin;
  logic        pwm;
  logic        irq;
  logic [31:0] rd;
  int          num_errors = 0;
  int          checked    = 0;
  int          irq_n      = 0;

  // Small fs divider keeps slow taps short
  cec_counter16 #(.FS_DIV(4)) cec_counter16_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .event_input_pin_i(ev_pin),
    .pwm_out_pin_o(pwm), .upper_timer_irq_o(irq)
  );
  cec_pulse_src cec_pulse_src_i (
    .clk_i(clk_i), .pwm_i(pwm), .pin_o(ev_pin)
  );

  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end

  task automatic conclude;
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle; ack sampled on the edge, released right after
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      chk({31'h0, wb_ack_o}, 32'h1);
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    wb(1'b1, adr, {24'h0, d}, 4'h1);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'h1);
    chk(rd, exp);
  endtask

  task automatic wait_pin(input logic val);
    int n;
    n = 0;
    while (pwm !== val && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, pwm}, {31'h0, val});
    if (pwm !== val) conclude();
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    num_errors++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({31'h0, pwm}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rdc(cec_pkg::OFS_CTRL, 32'h0);
    rdc(8'h18, 32'h0);
    wr(cec_pkg::OFS_STATUS, 8'hff);
    rdc(cec_pkg::OFS_STATUS, 32'h0);
    // Low lane disabled: the byte must stay untouched
    wb(1'b1, cec_pkg::OFS_PER_LO, 32'h000000aa, 4'he);
    rdc(cec_pkg::OFS_PER_LO, 32'h0);
    // Event mode, period 5, initial bit kept 0
    wr(cec_pkg::OFS_PER_LO, 8'h05);
    wr(cec_pkg::OFS_PER_HI, 8'h00);
    wr(cec_pkg::OFS_CTRL, 8'h1c);
    cec_pulse_src_i.pulse(2);
    rdc(cec_pkg::OFS_STATUS, 32'h0);
    wr(cec_pkg::OFS_CTRL, 8'h1d);
    cec_pulse_src_i.pulse(3);
    rdc(cec_pkg::OFS_STATUS, 32'h3);
    cec_pulse_src_i.pulse(2);
    rdc(cec_pkg::OFS_STATUS, 32'h0);
    chk(irq_n, 32'h1);
    cec_pulse_src_i.pulse(1);
    rdc(cec_pkg::OFS_STATUS, 32'h1);
    wr(cec_pkg::OFS_PER_LO, 8'h02);
    cec_pulse_src_i.pulse(1);
    chk(irq_n, 32'h2);
    // PWM mode clocked from the input pin
    wr(cec_pkg::OFS_CTRL, 8'h1f);
    cec_pulse_src_i.pulse(3);
    rdc(cec_pkg::OFS_STATUS, 32'h3);
    wr(cec_pkg::OFS_CTRL, 8'h1e);
    // Low-speed mode gates the fc tap
    wr(cec_pkg::OFS_CTRL, 8'h5b);
    repeat (20) @(posedge clk_i);
    rdc(cec_pkg::OFS_STATUS, 32'h0);
    wr(cec_pkg::OFS_CTRL, 8'h0f);
    repeat (80) @(posedge clk_i);
    wb(1'b0, cec_pkg::OFS_STATUS, 32'h0, 4'h1);
    chk({31'h0, rd[15:0] >= 16'd9 && rd[15:0] <= 16'd11}, 32'h1);
    // PWM at fc; duty 8000 while stopped, 1234 queued while running
    wr(cec_pkg::OFS_CTRL, 8'h1a);
    wr(cec_pkg::OFS_DUTY_LO, 8'h00);
    wr(cec_pkg::OFS_DUTY_HI, 8'h80);
    rdc(cec_pkg::OFS_DUTY_HI, 32'h80);
    wr(cec_pkg::OFS_CTRL, 8'h1b);
    wr(cec_pkg::OFS_DUTY_LO, 8'h34);
    wr(cec_pkg::OFS_DUTY_HI, 8'h12);
    rdc(cec_pkg::OFS_DUTY_HI, 32'h80);
    wait_pin(1'b0);
    wait_pin(1'b1);
    repeat (2) @(posedge clk_i);
    chk(irq_n, 32'h3);
    rdc(cec_pkg::OFS_DUTY_LO, 32'h34);
    rdc(cec_pkg::OFS_DUTY_HI, 32'h12);
    wait_pin(1'b0);
    repeat (2) @(posedge clk_i);
    chk(cec_pulse_src_i.fall_cyc - cec_pulse_src_i.rise_cyc, 32'h1234);
    // Stop holds level; later writes load the flop
    wr(cec_pkg::OFS_CTRL, 8'h1a);
    repeat (5) @(posedge clk_i);
    chk({31'h0, pwm}, 32'h0);
    wr(cec_pkg::OFS_CTRL, 8'h1a);
    repeat (3) @(posedge clk_i);
    chk({31'h0, pwm}, 32'h1);
    wr(cec_pkg::OFS_CTRL, 8'h9a);
    repeat (3) @(posedge clk_i);
    chk({31'h0, pwm}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
